// [verilog/svsc_pkg.sv]
// package for the supply supervisor control block
// assumes a 100 MHz aclk and an AXI4-Lite register bus
`default_nettype none
package svsc_pkg;
  localparam int          CLK_MHZ         = 100;
  // settling times in microseconds
  localparam int          TON_US          = 50;
  localparam int          TSETTLE_US      = 12;
  localparam int          TON_CYC         = TON_US * CLK_MHZ;
  localparam int          TSETTLE_CYC     = TSETTLE_US * CLK_MHZ;
  // printed offset 0x55 is not word aligned: kept as an index
  localparam logic [7:0]  CTL_IDX         = 8'h55;
  localparam logic [11:0] CTL_ADDR        = {2'h0, CTL_IDX, 2'h0};
  localparam logic [11:0] INT_STAT_ADDR   = 12'h200;
  localparam logic [11:0] INT_MASK_ADDR   = 12'h204;
  localparam int          LVL_HI          = 7;
  localparam int          LVL_LO          = 4;
  localparam int          BIT_RST_EN      = 3;
  localparam int          BIT_ACTIVE      = 2;
  localparam int          BIT_CMP         = 1;
  localparam int          BIT_FLAG        = 0;
  localparam logic [3:0]  LVL_OFF         = 4'h0;
  localparam logic [3:0]  LVL_EXT         = 4'hf;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  // interrupt status bits: flag set, settling done
  localparam int          IRQ_FLAG        = 0;
  localparam int          IRQ_READY       = 1;
  typedef enum logic [1:0] {ST_OFF, ST_SETTLE, ST_ON} svsc_state_t;
endpackage
`default_nettype wire

// [verilog/svsc_top.sv]
// supply supervisor control: level select, latched flag, reset request
// assumes an analog comparator outside and a brownout reset input
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`default_nettype none
module svsc_top
  import svsc_pkg::*;
#(
  parameter int TON_CYCLES    = TON_CYC,
  parameter int SETTLE_CYCLES = TSETTLE_CYC
)(
  input  wire logic        aclk,              // system clock
  input  wire logic        aresetn,           // bus reset, active low
  input  wire logic        brownout_resetn,   // brownout reset, active low
  input  wire logic        comparator_raw,    // comparator, high = supply ok
  output logic             supervisor_en,     // analog supervisor power
  output logic [3:0]       threshold_sel,     // internal threshold code
  output logic             ext_sense_sel,     // route external sense input
  output logic             por_request,       // power-on reset request
  output logic             irq,               // interrupt level
  input  wire logic [11:0] s_axi_awaddr,      // write address
  input  wire logic        s_axi_awvalid,     // write address valid
  output logic             s_axi_awready,     // write address ready
  input  wire logic [31:0] s_axi_wdata,       // write data
  input  wire logic [3:0]  s_axi_wstrb,       // write strobes
  input  wire logic        s_axi_wvalid,      // write data valid
  output logic             s_axi_wready,      // write data ready
  output logic [1:0]       s_axi_bresp,       // write response
  output logic             s_axi_bvalid,      // write response valid
  input  wire logic        s_axi_bready,      // write response ready
  input  wire logic [11:0] s_axi_araddr,      // read address
  input  wire logic        s_axi_arvalid,     // read address valid
  output logic             s_axi_arready,     // read address ready
  output logic [31:0]      s_axi_rdata,       // read data
  output logic [1:0]       s_axi_rresp,       // read response
  output logic             s_axi_rvalid,      // read data valid
  input  wire logic        s_axi_rready       // read data ready
);
  localparam int CW = $clog2(TON_CYCLES + 1);
  // the counter is sized from the longer delay, so the short one must fit
  if (TON_CYCLES < 1 || SETTLE_CYCLES < 1 || SETTLE_CYCLES > TON_CYCLES)
  begin
    $error("svsc_top: bad settling counts");
  end

  logic [3:0]  level_select;
  logic        reset_on_low_enable;
  logic        low_voltage_flag;
  logic [1:0]  int_status;
  logic [1:0]  int_mask;
  logic [2:0]  cmp_sync;
  logic        comparator_out;
  svsc_state_t state;
  logic [CW-1:0] settle_cnt;
  logic        aw_held, w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic [1:0]  bresp;
  logic        bvalid, rvalid;
  logic [31:0] rdata;
  logic [1:0]  rresp;

  logic [3:0]  next_level_select;
  logic        next_reset_on_low_enable;
  logic        next_low_voltage_flag;
  logic [1:0]  next_int_status;
  logic [1:0]  next_int_mask;
  logic [2:0]  next_cmp_sync;
  logic        next_comparator_out;
  svsc_state_t next_state;
  logic [CW-1:0] next_settle_cnt;
  logic        next_aw_held, next_w_held;
  logic [11:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic [1:0]  next_bresp;
  logic        next_bvalid, next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;

  logic        monitor_active;
  logic        wr_fire;
  logic        rd_fire;
  logic        low_cond;
  logic [7:0]  ctl_read;

  function automatic logic [CW-1:0] cyc(input int n);
    cyc = CW'(n - 1);
  endfunction

  // active only in the monitoring state
  assign monitor_active = (state == ST_ON);
  assign ctl_read = {level_select, reset_on_low_enable, monitor_active,
                     comparator_out, low_voltage_flag};
  // comparator low means supply below threshold
  assign low_cond = monitor_active & ~comparator_out;

  // powered only while level is non-zero
  assign supervisor_en = (level_select != LVL_OFF);
  // internal threshold for codes one to fourteen
  assign threshold_sel = (level_select == LVL_EXT) ? LVL_OFF : level_select;
  // all ones routes the external sense input
  assign ext_sense_sel = (level_select == LVL_EXT);
  // reset request follows flag when enabled and active
  // no request while the enable is clear
  assign por_request = reset_on_low_enable & low_voltage_flag & monitor_active;
  assign irq = |(int_status & int_mask);

  assign s_axi_awready = ~aw_held & ~bvalid;
  assign s_axi_wready  = ~w_held & ~bvalid;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_arready = ~rvalid;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;

  assign wr_fire = (aw_held | s_axi_awvalid) & (w_held | s_axi_wvalid) & ~bvalid;
  assign rd_fire = s_axi_arvalid & ~rvalid;

  always_comb
  begin
    logic [11:0] wa;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        lv_changed;
    wa = aw_held ? aw_addr : s_axi_awaddr;
    wd = w_held ? w_data : s_axi_wdata;
    ws = w_held ? w_strb : s_axi_wstrb;
    lv_changed = 1'b0;
    next_level_select        = level_select;
    next_reset_on_low_enable = reset_on_low_enable;
    next_low_voltage_flag    = low_voltage_flag;
    next_int_status          = int_status;
    next_int_mask            = int_mask;
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bresp   = bresp;
    next_bvalid  = bvalid & ~s_axi_bready;
    next_rvalid  = rvalid & ~s_axi_rready;
    next_rdata   = rdata;
    next_rresp   = rresp;
    // three stage synchroniser, change taken when stages two and three agree
    next_cmp_sync = {cmp_sync[1:0], comparator_raw};
    next_comparator_out = (cmp_sync[2] == cmp_sync[1]) ? cmp_sync[2] : comparator_out;
    if (s_axi_awvalid & s_axi_awready & ~wr_fire)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid & s_axi_wready & ~wr_fire)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      if (wa[11:2] == CTL_ADDR[11:2])
      begin
        if (ws[0])
        begin
          // active and comparator bits ignore writes
          next_level_select        = wd[LVL_HI:LVL_LO];
          next_reset_on_low_enable = wd[BIT_RST_EN];
          // software may only clear or keep the flag
          next_low_voltage_flag    = wd[BIT_FLAG] & low_voltage_flag;
          lv_changed = (wd[LVL_HI:LVL_LO] != level_select);
        end
      end
      else if (wa[11:2] == INT_STAT_ADDR[11:2])
      begin
        if (ws[0])
          next_int_status = int_status & ~wd[1:0];
      end
      else if (wa[11:2] == INT_MASK_ADDR[11:2])
      begin
        if (ws[0])
          next_int_mask = wd[1:0];
      end
      else
        next_bresp = RESP_SLVERR;
    end
    // set wins over a software clear
    if (low_cond)
      next_low_voltage_flag = 1'b1;
    if (low_cond & ~low_voltage_flag)
      next_int_status[IRQ_FLAG] = 1'b1;
    if ((state == ST_SETTLE) && (settle_cnt == '0) && !lv_changed)
      next_int_status[IRQ_READY] = 1'b1;
    if (rd_fire)
    begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = '0;
      if (s_axi_araddr[11:2] == CTL_ADDR[11:2])
        next_rdata = {24'h0, ctl_read};
      else if (s_axi_araddr[11:2] == INT_STAT_ADDR[11:2])
        next_rdata = {30'h0, int_status};
      else if (s_axi_araddr[11:2] == INT_MASK_ADDR[11:2])
        next_rdata = {30'h0, int_mask};
      else
        next_rresp = RESP_SLVERR;
    end
    // settling sequencer
    next_state      = state;
    next_settle_cnt = settle_cnt;
    case (state)
      ST_OFF:
        if (next_level_select != LVL_OFF)
        begin
          // long delay from off to on
          next_state      = ST_SETTLE;
          next_settle_cnt = cyc(TON_CYCLES);
        end
      ST_SETTLE:
        if (settle_cnt != '0)
          next_settle_cnt = settle_cnt - 1'b1;
        else
          next_state = ST_ON;
      ST_ON:
        next_state = ST_ON;
      default:
        next_state = ST_OFF;
    endcase
    if (state != ST_OFF && lv_changed)
    begin
      if (next_level_select == LVL_OFF)
        next_state = ST_OFF;
      else
      begin
        // settling holds active low, blocking flag and reset
        next_state      = ST_SETTLE;
        next_settle_cnt = cyc(SETTLE_CYCLES);
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    // control and flag cleared by brownout only
    if (!brownout_resetn)
    begin
      level_select        <= LVL_OFF;
      reset_on_low_enable <= 1'b0;
      low_voltage_flag    <= 1'b0;
      state               <= ST_OFF;
      settle_cnt          <= '0;
    end
    else
    begin
      level_select        <= next_level_select;
      reset_on_low_enable <= next_reset_on_low_enable;
      low_voltage_flag    <= next_low_voltage_flag;
      state               <= next_state;
      settle_cnt          <= next_settle_cnt;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      int_status     <= 2'h0;
      int_mask       <= 2'h0;
      cmp_sync       <= 3'h7;
      comparator_out <= 1'b1;
      aw_held        <= 1'b0;
      w_held         <= 1'b0;
      aw_addr        <= 12'h000;
      w_data         <= 32'h0;
      w_strb         <= 4'h0;
      bresp          <= RESP_OKAY;
      bvalid         <= 1'b0;
      rvalid         <= 1'b0;
      rdata          <= 32'h0;
      rresp          <= RESP_OKAY;
    end
    else
    begin
      int_status     <= next_int_status;
      int_mask       <= next_int_mask;
      cmp_sync       <= next_cmp_sync;
      comparator_out <= next_comparator_out;
      aw_held        <= next_aw_held;
      w_held         <= next_w_held;
      aw_addr        <= next_aw_addr;
      w_data         <= next_w_data;
      w_strb         <= next_w_strb;
      bresp          <= next_bresp;
      bvalid         <= next_bvalid;
      rvalid         <= next_rvalid;
      rdata          <= next_rdata;
      rresp          <= next_rresp;
    end
  end
endmodule
`default_nettype wire

// [bench/svsc_checker.sv]
// assertions on the supply supervisor control ports
// assumes one clock aclk and both resets synchronous, active low
`default_nettype none
module svsc_checker
  import svsc_pkg::*;
#(parameter int TON_CYCLES = TON_CYC, parameter int SETTLE_CYCLES = TSETTLE_CYC)
(
  input wire logic       aclk,            // clock
  input wire logic       aresetn,         // bus reset
  input wire logic       brownout_resetn, // brownout reset
  input wire logic       supervisor_en,   // power
  input wire logic [3:0] threshold_sel,   // threshold
  input wire logic       ext_sense_sel,   // external pick
  input wire logic       por_request,     // reset request
  input wire logic       s_axi_awvalid,   // aw valid
  input wire logic       s_axi_awready,   // aw ready
  input wire logic       s_axi_wvalid,    // w valid
  input wire logic       s_axi_wready,    // w ready
  input wire logic       s_axi_bvalid,    // b valid
  input wire logic       s_axi_bready,    // b ready
  input wire logic       s_axi_arvalid,   // ar valid
  input wire logic       s_axi_arready,   // ar ready
  input wire logic       s_axi_rvalid,    // r valid
  input wire logic       s_axi_rready     // r ready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || !brownout_resetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_off;
    !supervisor_en |-> threshold_sel == 4'h0 && !ext_sense_sel && !por_request;
  endproperty
  a_off: assert property (p_off) else $error("supervisor off but outputs live");
  property p_int;
    threshold_sel != 4'h0 |-> supervisor_en && !ext_sense_sel && threshold_sel != 4'hf;
  endproperty
  a_int: assert property (p_int) else $error("internal threshold code wrong");
  property p_ext;
    ext_sense_sel |-> supervisor_en && threshold_sel == 4'h0;
  endproperty
  a_ext: assert property (p_ext) else $error("external pick with threshold");
  // the sequencer moves on the same edge as the level register, so the gap is only slack
  property p_settle;
    $changed({ext_sense_sel, threshold_sel}) && supervisor_en |-> ##2 !por_request [*3];
  endproperty
  a_settle: assert property (p_settle) else $error("reset request while settling");
  property p_hold;
    $fell(por_request) |-> s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  a_hold: assert property (p_hold) else $error("reset request dropped unasked");
  property p_wr;
    s_wr_taken |=> s_axi_bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("no write response");
  property p_rd;
    s_rd_taken |=> s_axi_rvalid;
  endproperty
  a_rd: assert property (p_rd) else $error("no read response");
  property p_bdone;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_bdone: assert property (p_bdone) else $error("write response repeated");
endmodule
bind svsc_top svsc_checker #(.TON_CYCLES(TON_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES))
  i_svsc_checker (.*);
`default_nettype wire

// [bench/svsc_comparator_model.sv]
// model of the analog supply comparator feeding the supervisor block
// assumes the bench sets the supply code, external level and lag
`default_nettype none
module svsc_comparator_model (
  input  wire logic       aclk,           // clock
  input  wire logic       supervisor_en,  // power
  input  wire logic [3:0] threshold_sel,  // internal pick
  input  wire logic       ext_sense_sel,  // external pick
  input  wire logic [3:0] supply_code,    // supply as code
  input  wire logic       ext_low,        // external low
  input  wire logic [2:0] lag,            // answer delay
  output logic            comparator_raw  // high = ok
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       low;
  logic [7:0] hist = 8'h00;
  assign low = ext_sense_sel ? ext_low : (supply_code < threshold_sel);
  initial comparator_raw = 1'h1;
  // powered down it has no valid level, so it wanders instead of resting
  always @(posedge aclk)
  begin
    hist <= {hist[6:0], low};
    // an unknown enable before reset falls to the wandering branch, not to x
    if (supervisor_en)
      comparator_raw <= !hist[lag];
    else
      comparator_raw <= !comparator_raw;
  end
endmodule
`default_nettype wire

// [bench/tb_svsc_top.sv]
// testbench for the supply supervisor control block
// assumes svsc_top with its bound checker and the comparator model
`default_nettype none
module tb_svsc_top;
  import svsc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TON = 20;
  localparam int STL = 5;
  logic        aclk = 1'h0, aresetn = 1'h0, brownout_resetn = 1'h0, ext_low = 1'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [2:0]  lag = 3'h1;
  logic [3:0]  s_axi_wstrb = 4'h1, supply_code = 4'hf, r, c;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        comparator_raw, supervisor_en, ext_sense_sel, por_request, irq;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, bexp_q[$];
  logic [3:0]  threshold_sel;
  logic [33:0] exp_q[$], msk_q[$];
  int          errors = 0, tests_run = 0;
  always #5 aclk = ~aclk;
  svsc_top #(.TON_CYCLES(TON), .SETTLE_CYCLES(STL)) i_svsc_top (.*);
  svsc_comparator_model i_svsc_comparator_model (.*);
  task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
    tests_run++;
    if (s !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic bus(input logic rd, input logic [11:0] a, input logic [31:0] d);
    int   n;
    logic ta, tw, dn;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_arvalid <= rd;
    s_axi_rready <= rd;
    s_axi_awvalid <= !rd;
    s_axi_wvalid <= !rd;
    s_axi_bready <= !rd;
    dn = 1'h0;
    for (n = 0; n < 64 && !dn; n++)
    begin
      @(negedge aclk);
      ta = (s_axi_arvalid && s_axi_arready) || (s_axi_awvalid && s_axi_awready);
      tw = s_axi_wvalid && s_axi_wready;
      dn = rd ? s_axi_rvalid : s_axi_bvalid;
      @(posedge aclk);
      if (ta)
        s_axi_arvalid <= 1'h0;
      if (ta)
        s_axi_awvalid <= 1'h0;
      if (tw)
        s_axi_wvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
    s_axi_bready <= 1'h0;
    if (!dn)
    begin
      errors++;
      stop_test();
    end
    @(posedge aclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] rs = RESP_OKAY);
    bexp_q.push_back(rs);
    bus(1'h0, a, {24'h0, d});
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m,
                    input logic [1:0] rs = RESP_OKAY);
    msk_q.push_back({26'h3ffffff, m});
    exp_q.push_back({rs, 24'h0, e & m});
    bus(1'h1, a, 32'h0);
  endtask
  // settling end is learnt from the active bit, as software would
  task automatic poll_on();
    int k;
    k = 0;
    do
    begin
      bus(1'h1, CTL_ADDR, 32'h0);
      k++;
    end
    while (k < 64 && !s_axi_rdata[BIT_ACTIVE]);
    chk("poll active", 34'(s_axi_rdata[BIT_ACTIVE]), 34'h1);
    if (!s_axi_rdata[BIT_ACTIVE])
      stop_test();
  endtask
  // level outputs are looked at mid-cycle, once the edge's updates have landed
  task automatic pins(input logic [3:0] t, input logic x, input logic p, input logic i);
    repeat (2) @(negedge aclk);
    chk("pins", 34'({threshold_sel, ext_sense_sel, por_request, irq, supervisor_en}),
        34'({t, x, p, i, (t != 4'h0) || x}));
    @(posedge aclk);
  endtask
  always @(posedge aclk)
  begin
    if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0)
      chk("read", {s_axi_rresp, s_axi_rdata} & msk_q.pop_front(), exp_q.pop_front());
    if (s_axi_bvalid && s_axi_bready && bexp_q.size() > 0)
      chk("bresp", 34'(s_axi_bresp), 34'(bexp_q.pop_front()));
  end
  initial
  begin
    void'($urandom(50));
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    brownout_resetn <= 1'h1;
    lag <= 3'($urandom_range(1, 6));
    @(posedge aclk);
    rd(CTL_ADDR, 8'h00, 8'hfd);
    rd(12'h010, 8'h00, 8'hff, RESP_SLVERR);
    wr(12'h010, 8'h00, RESP_SLVERR);
    wr(CTL_ADDR, 8'h04);
    rd(CTL_ADDR, 8'h00, 8'hfd);
    wr(CTL_ADDR, 8'h30);
    rd(CTL_ADDR, 8'h30, 8'hfd);
    pins(4'h3, 1'h0, 1'h0, 1'h0);
    repeat (TON - 12) @(posedge aclk);
    rd(CTL_ADDR, 8'h30, 8'hfd);
    repeat (10) @(posedge aclk);
    rd(CTL_ADDR, 8'h36, 8'hff);
    rd(INT_STAT_ADDR, 8'h02, 8'h02);
    $display("test turn-on end");
    supply_code <= 4'h2;
    // comparator lag plus three sync stages plus the flag edge
    repeat (16) @(posedge aclk);
    rd(CTL_ADDR, 8'h35, 8'hff);
    pins(4'h3, 1'h0, 1'h0, 1'h0);
    wr(CTL_ADDR, 8'h30);
    rd(CTL_ADDR, 8'h35, 8'hff);
    rd(INT_STAT_ADDR, 8'h01, 8'h01);
    wr(INT_MASK_ADDR, 8'h01);
    pins(4'h3, 1'h0, 1'h0, 1'h1);
    supply_code <= 4'hf;
    repeat (16) @(posedge aclk);
    rd(CTL_ADDR, 8'h37, 8'hff);
    wr(INT_STAT_ADDR, 8'h01);
    wr(CTL_ADDR, 8'h30);
    rd(CTL_ADDR, 8'h36, 8'hff);
    pins(4'h3, 1'h0, 1'h0, 1'h0);
    $display("test flag end");
    wr(CTL_ADDR, 8'h58);
    rd(CTL_ADDR, 8'h58, 8'hfd);
    repeat (STL + 4) @(posedge aclk);
    rd(CTL_ADDR, 8'h5e, 8'hff);
    supply_code <= 4'h4;
    repeat (16) @(posedge aclk);
    pins(4'h5, 1'h0, 1'h1, 1'h1);
    wr(CTL_ADDR, 8'hf8);
    supply_code <= 4'hf;
    pins(4'h0, 1'h1, 1'h0, 1'h1);
    wr(INT_STAT_ADDR, 8'h01);
    $display("test reset request end");
    r = 4'($urandom());
    for (int i = 0; i < 16; i++)
    begin
      c = 4'(i) ^ r;
      wr(CTL_ADDR, {c, 4'h0});
      pins((c == 4'hf) ? 4'h0 : c, c == 4'hf, 1'h0, 1'h0);
    end
    wr(CTL_ADDR, 8'hf8);
    ext_low <= 1'h1;
    // the random loop may have left the supervisor off, so the delay is unknown
    poll_on();
    repeat (16) @(posedge aclk);
    rd(CTL_ADDR, 8'hfd, 8'hff);
    ext_low <= 1'h0;
    $display("test level codes end");
    wr(CTL_ADDR, 8'h70);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(CTL_ADDR, 8'h70, 8'hf8);
    brownout_resetn <= 1'h0;
    repeat (2) @(posedge aclk);
    brownout_resetn <= 1'h1;
    @(posedge aclk);
    rd(CTL_ADDR, 8'h00, 8'hfd);
    $display("test resets end");
    stop_test();
  end
endmodule
`default_nettype wire
